// ### hdl/tws_defs.svh
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// ==========================================================================
// Register map (byte addresses on APB).
`define TWS_OFF_ADDR 8'h00
`define TWS_OFF_CTRL 8'h04
`define TWS_OFF_STAT 8'h08
`define TWS_OFF_DATA 8'h0c
`define TWS_OFF_SLEEP 8'h10

// ==========================================================================
// Reset values.
`define TWS_ADDR_RST 8'h00
`define TWS_CTRL_RST 8'h00
`define TWS_DATA_RST 8'hff
`define TWS_SLEEP_RST 1'b0

// ==========================================================================
// Field positions.
`define TWS_GC_EN_BIT 0
`define TWS_RW_BIT 0
`define TWS_SLEEP_BIT 0
`define TWS_GC_ADDR 7'h00
`define TWS_FLAG_BIT 7
`define TWS_START_BIT 5

// ==========================================================================
// Status codes, low three bits (prescaler field) always zero.
`define TWS_ST_IDLE 8'hf8
`define TWS_ST_OWN_W 8'h60
`define TWS_ST_ARB_OWN_W 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_ST_DATA_ACK 8'h80
`define TWS_ST_DATA_NACK 8'h88
`define TWS_ST_GC_DATA_ACK 8'h90
`define TWS_ST_GC_DATA_NACK 8'h98

// ==========================================================================
// Bit count of one byte on the bus.
`define TWS_BYTE_BITS 4'h8

`endif

// ### hdl/tws_pkg.sv
package tws_pkg;

  // ========================================================================
  // Bus pins as sampled by the system clock.
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_s;

  // ========================================================================
  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic event_pending_flag;
    logic acknowledge_enable;
    logic start_request;
    logic stop_request;
    logic write_collision_flag;
    logic interface_enable;
    logic reserved;
    logic event_irq_enable;
  } tws_ctrl_s;

  // ========================================================================
  // Slave receiver states.
  typedef enum logic [6:0] {
    ST_IDLE     = 7'b000_0001,
    ST_ADDR     = 7'b000_0010,
    ST_ADDR_ACK = 7'b000_0100,
    ST_DATA     = 7'b000_1000,
    ST_DATA_ACK = 7'b001_0000,
    ST_HOLD     = 7'b010_0000,
    ST_UNADDR   = 7'b100_0000
  } tws_state_e;

endpackage

// ### hdl/tws_sync.sv
`timescale 1ns/100ps
`default_nettype none

module tws_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Signals from outside the clock domain
  input wire logic [WIDTH-1:0] async_in,
  // Signals after two flip-flops
  output logic [WIDTH-1:0] sync_out
);

  // ========================================================================
  // Two flip-flops per bit; the first stage feeds only the second.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### hdl/tws_slave_rx.sv
// Operation
// - Answer as slave only to the 7-bit address in own-address bits 7..1.
// - Own-address bit 0 set enables general call address 0x00; clear ignores it.
// - Address or general call is acknowledged only while acknowledge enable is one.
// - After a match, direction bit 0 enters receive; 1 means transmit (here a read address is never matched or acknowledged).
// - Own address with write bit sets the event flag and a valid status.
// - Status prescaler bits read as zero.
// - Addressed after lost arbitration, report the arbitration-lost codes.
// - Acknowledge enable cleared mid-transfer gives not-acknowledge after next byte.
// - With acknowledge enable zero, keep watching the bus; recognition resumes later.
// - In deep sleep, still match and acknowledge, running off the bus clock (here matching stays on the system clock, sampling SCL).
// - On match in deep sleep, wake and hold SCL low until flag cleared.
// - After deep sleep wake the data register may not hold the last byte.
// - Own write address acknowledged reports 0x60; next byte acknowledge follows enable.
// - Arbitration lost then own write address reports 0x68, same acknowledge choice.
// - General call acknowledged reports 0x70, or 0x78 after lost arbitration.
// - Data byte acknowledged reports 0x80 with the byte in the data register.
// - Data byte not-acknowledged reports 0x88; flag clear returns to unaddressed.
// - Leaving 0x88, recognition needs acknowledge enable; start request sends START later.
`timescale 1ns/100ps
`default_nettype none
`include "tws_defs.svh"

module tws_slave_rx #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Master side of the interface and power control
  input wire logic master_arb_lost,
  output logic start_on_free,
  output logic wake_req
);

  // ========================================================================
  // Register hit decoding.
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_hit = (a == ADDR_W'(off));
  endfunction

  // ========================================================================
  // State and registers.
  tws_pkg::tws_state_e state;
  tws_pkg::tws_state_e next_state;
  tws_pkg::tws_ctrl_s ctrl;
  tws_pkg::tws_ctrl_s next_ctrl;
  tws_pkg::tws_pins_s pins_raw;
  tws_pkg::tws_pins_s pins;
  tws_pkg::tws_pins_s pins_prev;
  logic [7:0] own_slave_address;
  logic [7:0] bus_status_code_reg;
  logic [7:0] bus_data_reg;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic deep_sleep;
  logic arb_lost_seen;
  logic gc_addressed;
  logic data_acked;
  logic start_pending;

  // ========================================================================
  // Pin synchronisers and bus condition detection.
  assign pins_raw.scl = scl_in;
  assign pins_raw.sda = sda_in;

  tws_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_prev <= '1;
    end else begin
      pins_prev <= pins;
    end
  end

  // The bus clock is sampled here, so deep sleep keeps matching on its edges.
  wire scl_rise = pins.scl & ~pins_prev.scl;
  wire scl_fall = ~pins.scl & pins_prev.scl;
  wire start_cond = pins.scl & pins_prev.scl & pins_prev.sda & ~pins.sda;
  wire stop_cond = pins.scl & pins_prev.scl & ~pins_prev.sda & pins.sda;
  wire bus_free = (state == tws_pkg::ST_IDLE) & pins.scl & pins.sda;

  // ========================================================================
  // APB decode: one wait state, then the answer.
  wire apb_access = psel & penable & ~pready;
  wire apb_take = psel & penable & pready & pwrite;
  wire hit_addr = addr_hit(paddr, `TWS_OFF_ADDR);
  wire hit_ctrl = addr_hit(paddr, `TWS_OFF_CTRL);
  wire hit_stat = addr_hit(paddr, `TWS_OFF_STAT);
  wire hit_data = addr_hit(paddr, `TWS_OFF_DATA);
  wire hit_sleep = addr_hit(paddr, `TWS_OFF_SLEEP);
  wire hit_any = hit_addr | hit_ctrl | hit_stat | hit_data | hit_sleep;
  wire wr_addr = apb_take & hit_addr;
  wire wr_ctrl = apb_take & hit_ctrl;
  wire wr_data = apb_take & hit_data;
  wire wr_sleep = apb_take & hit_sleep;
  wire flag_clr = wr_ctrl & pwdata[`TWS_FLAG_BIT];
  wire [7:0] ctrl_rd = ctrl;
  wire [7:0] rd_byte = hit_addr ? own_slave_address :
                       hit_ctrl ? ctrl_rd :
                       hit_stat ? bus_status_code_reg :
                       hit_data ? bus_data_reg :
                       hit_sleep ? {7'h00, deep_sleep} : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~hit_any;
      prdata <= (apb_access & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ========================================================================
  // Address and direction evaluation.
  wire own_hit = (shift[7:1] == own_slave_address[7:1]);
  wire gc_hit = (shift[7:1] == `TWS_GC_ADDR) & own_slave_address[`TWS_GC_EN_BIT];
  wire dir_write = ~shift[`TWS_RW_BIT];
  wire addr_match = ctrl.interface_enable & ctrl.acknowledge_enable & dir_write &
                    (own_hit | gc_hit);
  wire byte_done = scl_fall & (bit_cnt == `TWS_BYTE_BITS);
  wire in_addr_ack = (state == tws_pkg::ST_ADDR_ACK);
  wire in_data_ack = (state == tws_pkg::ST_DATA_ACK);
  wire event_set = (in_addr_ack | in_data_ack) & scl_fall & ~start_cond & ~stop_cond;
  wire addr_event = in_addr_ack & event_set;
  wire data_event = in_data_ack & event_set;
  wire nack_sent = ~data_acked & (bus_status_code_reg != `TWS_ST_IDLE);

  // ========================================================================
  // Next state.
  always_comb begin
    next_state = state;
    if (!ctrl.interface_enable) begin
      next_state = tws_pkg::ST_IDLE;
    end else if (start_cond) begin
      next_state = tws_pkg::ST_ADDR;
    end else if (stop_cond) begin
      next_state = tws_pkg::ST_IDLE;
    end else begin
      unique case (state)
        tws_pkg::ST_IDLE: begin
          next_state = tws_pkg::ST_IDLE;
        end
        tws_pkg::ST_ADDR: begin
          if (byte_done) begin
            next_state = addr_match ? tws_pkg::ST_ADDR_ACK : tws_pkg::ST_UNADDR;
          end
        end
        tws_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_state = tws_pkg::ST_HOLD;
          end
        end
        tws_pkg::ST_DATA: begin
          if (byte_done) begin
            next_state = tws_pkg::ST_DATA_ACK;
          end
        end
        tws_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            next_state = tws_pkg::ST_HOLD;
          end
        end
        tws_pkg::ST_HOLD: begin
          if (flag_clr) begin
            next_state = nack_sent ? tws_pkg::ST_UNADDR : tws_pkg::ST_DATA;
          end
        end
        tws_pkg::ST_UNADDR: begin
          next_state = tws_pkg::ST_UNADDR;
        end
        default: begin
          next_state = tws_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= tws_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Bit counter and receive shifter.
  wire shifting = (state == tws_pkg::ST_ADDR) | (state == tws_pkg::ST_DATA);
  wire cnt_clear = start_cond | (next_state == tws_pkg::ST_DATA && state != tws_pkg::ST_DATA);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= 4'h0;
      shift <= 8'h00;
    end else if (cnt_clear) begin
      bit_cnt <= 4'h0;
    end else if (shifting & scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift <= {shift[6:0], pins.sda};
    end
  end

  // ========================================================================
  // Acknowledge decision, status and data capture.
  // The acknowledge choice is the enable bit as it stands when the byte ends.
  wire byte_ack = ctrl.acknowledge_enable;
  wire [7:0] addr_code = gc_hit ?
                         (arb_lost_seen ? `TWS_ST_ARB_GC : `TWS_ST_GC) :
                         (arb_lost_seen ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W);
  wire [7:0] data_code = gc_addressed ?
                         (data_acked ? `TWS_ST_GC_DATA_ACK : `TWS_ST_GC_DATA_NACK) :
                         (data_acked ? `TWS_ST_DATA_ACK : `TWS_ST_DATA_NACK);
  wire [7:0] next_status = addr_event ? addr_code :
                           data_event ? data_code :
                           (state == tws_pkg::ST_HOLD && !flag_clr) ? bus_status_code_reg :
                           (state == tws_pkg::ST_HOLD) ? `TWS_ST_IDLE : bus_status_code_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_status_code_reg <= `TWS_ST_IDLE;
      data_acked <= 1'b0;
      gc_addressed <= 1'b0;
    end else begin
      bus_status_code_reg <= next_status;
      if (state == tws_pkg::ST_DATA && byte_done) begin
        data_acked <= byte_ack;
      end else if (addr_event) begin
        data_acked <= 1'b1;
      end
      if (addr_event) begin
        gc_addressed <= gc_hit;
      end
    end
  end

  // Received bytes land here; the address phase of a wake never touches it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_data_reg <= `TWS_DATA_RST;
    end else if (state == tws_pkg::ST_DATA && byte_done) begin
      bus_data_reg <= shift;
    end else if (wr_data & ctrl.event_pending_flag) begin
      bus_data_reg <= pwdata[7:0];
    end
  end

  // ========================================================================
  // Own address, sleep and arbitration bookkeeping.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      own_slave_address <= `TWS_ADDR_RST;
    end else if (wr_addr) begin
      own_slave_address <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deep_sleep <= `TWS_SLEEP_RST;
      wake_req <= 1'b0;
    end else begin
      wake_req <= addr_event & deep_sleep;
      if (addr_event) begin
        deep_sleep <= 1'b0;
      end else if (wr_sleep) begin
        deep_sleep <= pwdata[`TWS_SLEEP_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arb_lost_seen <= 1'b0;
    end else begin
      arb_lost_seen <= master_arb_lost | (arb_lost_seen & ~addr_event);
    end
  end

  // A START after leaving the not-acknowledged state waits for a free bus.
  wire leave_nack = (state == tws_pkg::ST_HOLD) & flag_clr & nack_sent;
  wire start_set = leave_nack & pwdata[`TWS_START_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_pending <= 1'b0;
      start_on_free <= 1'b0;
    end else begin
      start_pending <= start_set | (start_pending & ~bus_free);
      start_on_free <= start_pending & bus_free;
    end
  end

  // ========================================================================
  // Control register: the hardware set of the flag wins over a clear.
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = tws_pkg::tws_ctrl_s'(pwdata[7:0]);
      next_ctrl.write_collision_flag = ctrl.write_collision_flag;
      next_ctrl.reserved = 1'b0;
    end
    if (wr_data) begin
      next_ctrl.write_collision_flag = ~ctrl.event_pending_flag;
    end
    next_ctrl.event_pending_flag = event_set | (ctrl.event_pending_flag & ~flag_clr);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= tws_pkg::tws_ctrl_s'(`TWS_CTRL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ========================================================================
  // Pin drivers: acknowledge on SDA, stretching on SCL.
  wire next_ack_drive = (next_state == tws_pkg::ST_ADDR_ACK) |
                        ((next_state == tws_pkg::ST_DATA_ACK) &
                         ((state == tws_pkg::ST_DATA) ? byte_ack : data_acked));
  wire next_stretch = (next_state == tws_pkg::ST_HOLD) & next_ctrl.event_pending_flag;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_oe <= next_ack_drive;
      scl_oe <= next_stretch;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### dv/tws_sva.sv
`timescale 1ns/100ps
`default_nettype none

module tws_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Bus pins and pulses
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic start_on_free,
  input wire logic wake_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Completed control writes and the acknowledge enable they leave.
  logic ack_en;
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == ADDR_W'(4);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_en <= 1'b0;
    end else if (wr_ctrl) begin
      ack_en <= pwdata[6];
    end
  end
  // ==========
  // Checks.
  a_ack_enabled: assert property ($rose(sda_oe) |-> ack_en)
    else $error("acknowledge while disabled");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  a_event_stretch: assert property ($fell(sda_oe) |-> ##[0:6] scl_oe)
    else $error("no stretch after acknowledge");
  a_stretch_holds: assert property (scl_oe && !wr_ctrl && !$past(wr_ctrl) |=> scl_oe)
    else $error("stretch dropped without clear");
  a_stretch_release: assert property (scl_oe && wr_ctrl && pwdata[7] |-> ##[1:2] !scl_oe)
    else $error("stretch kept after clear");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request too long");
  a_start_free: assert property (start_on_free |-> scl_in && sda_in)
    else $error("start request on busy bus");
endmodule

`default_nettype wire

// ### dv/tws_bus_master.sv
`timescale 1ns/100ps
`default_nettype none

module tws_bus_master (
  // Lines as seen on the wire
  input wire logic scl,
  input wire logic sda,
  // Open-drain pulls, high pulls the line low
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // ==========
  // One bit; the high phase waits out any clock stretch by the slave.
  task automatic put_bit(input logic b, output logic seen);
    #16 sda_pull = !b;
    #16 scl_pull = 1'b0;
    wait (scl === 1'b1);
    #32 seen = sda;
    scl_pull = 1'b1;
  endtask
  task automatic start;
    #16 sda_pull = 1'b1;
    #32 scl_pull = 1'b1;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
    end
    put_bit(1'b1, s);
    ack = !s;
    #40;
  endtask
  task automatic stop;
    #16 sda_pull = 1'b1;
    #16 scl_pull = 1'b0;
    wait (scl === 1'b1);
    #32 sda_pull = 1'b0;
    #64;
  endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // ==========
  // Signals, open-drain wires and the case table.
  logic clk, sys_rst, psel, penable, pwrite, arb, perr, ack, sof, woke, m_scl, m_sda;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, start_on_free, wake_req;
  logic [7:0] paddr, rd;
  logic [31:0] pwdata, prdata;
  wire logic scl = !(scl_oe === 1'b1 || m_scl);
  wire logic sda = !(sda_oe === 1'b1 || m_sda);
  int err_total = 0;
  int tests_run = 0;
  typedef struct {
    logic [7:0] own, sla, st1, st2;
    logic arb, ack;
  } tws_row_s;
  tws_row_s rows [7] = '{
    '{8'h40, 8'h40, 8'h60, 8'h80, 1'b0, 1'b1},
    '{8'h40, 8'h42, 8'h00, 8'h00, 1'b0, 1'b0},
    '{8'h40, 8'h41, 8'h00, 8'h00, 1'b0, 1'b0},
    '{8'h41, 8'h00, 8'h70, 8'h90, 1'b0, 1'b1},
    '{8'h40, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
    '{8'hfe, 8'hfe, 8'h68, 8'h80, 1'b1, 1'b1},
    '{8'h41, 8'h00, 8'h78, 8'h90, 1'b1, 1'b1}
  };
  tws_slave_rx dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .master_arb_lost(arb),
    .start_on_free(start_on_free), .wake_req(wake_req));
  tws_bus_master bus_u (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));
  // ==========
  // Bus tasks and checking.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (start_on_free === 1'b1) sof <= 1'b1;
    if (wake_req === 1'b1) woke <= 1'b1;
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  // ==========
  // Reset, the table, then the awkward cases.
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, arb, sof, woke} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(8'h08, 8'hf8, "status");
    rdchk(8'h0c, 8'hff, "data");
    rdchk(8'h00, 8'h00, "address");
    rdchk(8'h04, 8'h00, "control");
    rdchk(8'h14, 8'h00, "unmapped");
    chk("slverr", 8'h01, {7'h0, perr});
    apb(1'b1, 8'h0c, 8'h33);
    rdchk(8'h04, 8'h08, "collision");
    rdchk(8'h0c, 8'hff, "data kept");
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, rows[i].own);
      apb(1'b1, 8'h04, 8'h44);
      if (rows[i].arb) begin
        @(posedge clk);
        arb <= 1'b1;
        @(posedge clk);
        arb <= 1'b0;
      end
      bus_u.start();
      bus_u.send(rows[i].sla, ack);
      chk("address ack", {7'h0, rows[i].ack}, {7'h0, ack});
      if (ack) begin
        rdchk(8'h08, rows[i].st1, "status");
        apb(1'b1, 8'h04, 8'hc4);
        bus_u.send(8'ha5, ack);
        chk("data ack", 8'h01, {7'h0, ack});
        rdchk(8'h08, rows[i].st2, "status");
        rdchk(8'h0c, 8'ha5, "data");
        apb(1'b1, 8'h04, 8'hc4);
      end
      bus_u.stop();
      $display("row %0d done", i);
    end
    apb(1'b1, 8'h00, 8'h40);
    bus_u.start();
    bus_u.send(8'h40, ack);
    apb(1'b1, 8'h04, 8'h84);
    bus_u.send(8'h5a, ack);
    chk("data nack", 8'h00, {7'h0, ack});
    rdchk(8'h08, 8'h88, "status");
    apb(1'b1, 8'h04, 8'he4);
    bus_u.stop();
    for (int n = 0; n < 50 && sof !== 1'b1; n++) @(posedge clk);
    chk("start on free", 8'h01, {7'h0, sof});
    $display("nack test done");
    apb(1'b1, 8'h00, 8'h41);
    bus_u.start();
    bus_u.send(8'h00, ack);
    rdchk(8'h08, 8'h70, "status");
    apb(1'b1, 8'h04, 8'h84);
    bus_u.send(8'h3c, ack);
    chk("gc data nack", 8'h00, {7'h0, ack});
    rdchk(8'h08, 8'h98, "status");
    apb(1'b1, 8'h04, 8'hc4);
    bus_u.stop();
    $display("gc nack test done");
    apb(1'b1, 8'h04, 8'h04);
    bus_u.start();
    bus_u.send(8'h40, ack);
    chk("disabled ack", 8'h00, {7'h0, ack});
    bus_u.stop();
    apb(1'b1, 8'h04, 8'h44);
    bus_u.start();
    bus_u.send(8'h40, ack);
    chk("resumed ack", 8'h01, {7'h0, ack});
    rdchk(8'h08, 8'h60, "status");
    apb(1'b1, 8'h04, 8'hc4);
    bus_u.stop();
    $display("enable test done");
    apb(1'b1, 8'h10, 8'h01);
    bus_u.start();
    bus_u.send(8'h40, ack);
    chk("sleep ack", 8'h01, {7'h0, ack});
    chk("wake", 8'h01, {7'h0, woke});
    chk("stretch", 8'h01, {7'h0, scl_oe});
    rdchk(8'h10, 8'h00, "sleep");
    rdchk(8'h08, 8'h60, "status");
    rdchk(8'h0c, 8'h3c, "data after wake");
    apb(1'b1, 8'h04, 8'hc4);
    bus_u.stop();
    $display("sleep test done");
    bus_u.start();
    bus_u.send(8'h40, ack);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("reset stretch", 8'h00, {7'h0, scl_oe});
    rdchk(8'h08, 8'hf8, "status");
    rdchk(8'h04, 8'h00, "control");
    bus_u.stop();
    $display("mid-run reset test done");
    complete_run();
  end
endmodule

bind tws_slave_rx tws_sva #(.ADDR_W(ADDR_W)) sva_u (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .start_on_free(start_on_free),
  .wake_req(wake_req));

`default_nettype wire
